// file: core/cph_cop_port.sv
`timescale 1ns/1ps
`default_nettype none
module cph_cop_port
   import cph_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      cop_instr_o,
   output logic             cop_offer_o,
   output logic [31:0]      cop_wdata_o,
   input  wire logic        coprocessor_absent_i,
   input  wire logic        cop_last_i,
   input  wire logic [31:0] cop_rdata_i,
   output logic [31:0]      mem_addr_o,
   output logic             mem_req_o,
   output logic             mem_write_o,
   input  wire logic        mem_abort_i
);
   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic        absent_m_q, absent_s_q, last_m_q, last_s_q, abort_m_q, abort_s_q;
   logic [31:0] rdata_m_q, rdata_s_q;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         absent_m_q <= 1'b1;
         absent_s_q <= 1'b1;
         last_m_q   <= 1'b0;
         last_s_q   <= 1'b0;
         abort_m_q  <= 1'b0;
         abort_s_q  <= 1'b0;
         rdata_m_q  <= RST_WORD;
         rdata_s_q  <= RST_WORD;
      end else begin
         absent_m_q <= coprocessor_absent_i;
         absent_s_q <= absent_m_q;
         last_m_q   <= cop_last_i;
         last_s_q   <= last_m_q;
         abort_m_q  <= mem_abort_i;
         abort_s_q  <= abort_m_q;
         rdata_m_q  <= cop_rdata_i;
         rdata_s_q  <= rdata_m_q;
      end
   end
   // ---------------------------------------------
   // Programmer state and decode
   // ---------------------------------------------
   cph_state_e  st_q;
   logic [2:0]  cnt_q;
   logic [7:0]  words_q;
   logic [6:0]  stat_q;
   logic [31:0] instr_q, base_q, pc_q, flags_q, xfer_q, addr_q, wdata_q, hrdata_q;
   logic        mode32_q, ph_wr_q;
   logic [7:0]  ph_addr_q;
   logic [31:0] cp15_q [16];
   logic        busy, wr_en, go, cond_pass, is_ldst, is_rt, is_cdp, is_undef;
   logic        cop_op, internal, base_pc, rd_pc, l_bit, w_bit, illegal, mode_now;
   logic        chk_end, base_wb, reg_in, flags_ld, xfer_ld;
   logic [31:0] pc8, base_val, off, mod_addr, first, nxt, mrc_val, mcr_val, rd_mux;
   cph_cond_eval u_cond (
      .cond_i (instr_q[B_COND +: 4]),
      .nzcv_i (flags_q[31:28]),
      .pass_o (cond_pass)
   );
   assign busy     = st_q != S_IDLE;
   assign is_ldst  = instr_q[27:25] == CLS_LDST;
   assign is_rt    = instr_q[27:24] == CLS_REGOP && instr_q[B_BIT4];
   assign is_cdp   = instr_q[27:24] == CLS_REGOP && !instr_q[B_BIT4];
   assign is_undef = instr_q[27:25] == CLS_UNDEF && instr_q[B_BIT4];
   assign cop_op   = is_ldst || is_rt || is_cdp;
   assign internal = is_rt && instr_q[B_CPN +: 4] == COP_ONCHIP;
   assign base_pc  = instr_q[B_BASE +: 4] == PC_REG;
   assign rd_pc    = instr_q[B_RD +: 4] == PC_REG;
   assign l_bit    = instr_q[B_L];
   assign w_bit    = instr_q[B_W];
   // PC base without status bits
   assign pc8      = pc_q + PC_BASE_OFS;
   assign base_val = base_pc ? (mode32_q ? pc8 : pc8 & PC26_MASK) : base_q;
   assign off      = {24'h0, instr_q[7:0]} << OFS_SHIFT;
   assign mod_addr = instr_q[B_U] ? base_val + off : base_val - off;
   assign first    = instr_q[B_P] ? mod_addr : base_val;
   assign illegal  = !mode32_q && first[31:26] != 6'h00;
   assign nxt      = mode32_q ? addr_q + WORD_BYTES
                              : (addr_q + WORD_BYTES) & ADDR26_MASK;
   // Mode written with go applies to the word latched at go
   assign mode_now = go ? hwdata_i[CTRL_MODE32] : mode32_q;
   // Source word for a processor-to-coprocessor move
   always_comb begin
      if (!rd_pc) begin
         mcr_val = xfer_q;
      end else if (mode_now) begin
         mcr_val = pc_q + PC_XFER_OFS;
      end else begin
         mcr_val = {flags_q[31:26], pc_q[25:2], flags_q[1:0]};
      end
   end
   assign mrc_val  = internal ? cp15_q[instr_q[B_BASE +: 4]] : rdata_s_q;
   assign chk_end  = st_q == S_XCHK && cnt_q == ABORT_WAIT - 3'h1;
   assign base_wb  = chk_end && (abort_s_q || last_s_q) && w_bit && !base_pc;
   assign reg_in   = st_q == S_REG && l_bit;
   assign flags_ld = reg_in && rd_pc;
   assign xfer_ld  = reg_in && !rd_pc;
   // ---------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------
   always_comb begin
      case (haddr_i[7:0])
         REG_CTRL:   rd_mux = {30'h0, mode32_q, 1'b0};
         REG_INSTR:  rd_mux = instr_q;
         REG_BASE:   rd_mux = base_q;
         REG_PC:     rd_mux = pc_q;
         REG_FLAGS:  rd_mux = flags_q;
         REG_XFER:   rd_mux = xfer_q;
         REG_STATUS: rd_mux = {16'h0, words_q, 1'b0, stat_q[6:1], busy};
         default:    rd_mux = RST_WORD;
      endcase
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 8'h00;
         hrdata_q  <= RST_WORD;
      end else begin
         ph_wr_q   <= hsel_i && htrans_i[1] && hready_i && hwrite_i && hsize_i == SIZE_WORD;
         ph_addr_q <= haddr_i[7:0];
         if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
            hrdata_q <= rd_mux;
         end
      end
   end
   assign hrdata_o    = hrdata_q;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   // Writes while busy are dropped
   assign wr_en = ph_wr_q && !busy;
   assign go    = wr_en && ph_addr_q == REG_CTRL && hwdata_i[CTRL_GO];
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mode32_q <= 1'b0;
         instr_q  <= RST_WORD;
         base_q   <= RST_WORD;
         pc_q     <= RST_WORD;
         flags_q  <= RST_WORD;
         xfer_q   <= RST_WORD;
      end else begin
         if (wr_en) begin
            case (ph_addr_q)
               REG_CTRL:  mode32_q <= hwdata_i[CTRL_MODE32];
               REG_INSTR: instr_q  <= hwdata_i;
               REG_BASE:  base_q   <= hwdata_i;
               REG_PC:    pc_q     <= hwdata_i;
               REG_FLAGS: flags_q  <= hwdata_i;
               REG_XFER:  xfer_q   <= hwdata_i;
               default:   ;
            endcase
         end
         if (base_wb) begin
            base_q <= mod_addr;
         end
         if (flags_ld) begin
            flags_q[31:28] <= mrc_val[31:28];
         end
         if (xfer_ld) begin
            xfer_q <= mrc_val;
         end
      end
   end
   // ---------------------------------------------
   // Internal control coprocessor
   // ---------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < 16; i++) begin
            cp15_q[i] <= RST_WORD;
         end
      end else if (st_q == S_REG && internal && !l_bit) begin
         cp15_q[instr_q[B_BASE +: 4]] <= wdata_q;
      end
   end
   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_q    <= S_IDLE;
         cnt_q   <= 3'h0;
         words_q <= 8'h00;
         stat_q  <= 7'h00;
         addr_q  <= RST_WORD;
         wdata_q <= RST_WORD;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               if (go) begin
                  stat_q  <= 7'h00;
                  words_q <= 8'h00;
                  cnt_q   <= 3'h0;
                  wdata_q <= mcr_val;
                  if (!cond_pass) begin
                     stat_q[STB_SKIP] <= 1'b1;
                     st_q             <= S_DONE;
                  end else if (internal) begin
                     st_q <= S_REG;
                  end else if (cop_op || is_undef) begin
                     st_q <= S_OFFER;
                  end else begin
                     stat_q[STB_NOTCOP] <= 1'b1;
                     st_q               <= S_DONE;
                  end
               end
            end
            S_OFFER: begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == CLAIM_WAIT - 3'h1) begin
                  cnt_q <= 3'h0;
                  if (absent_s_q) begin
                     stat_q[STB_UNDEF] <= 1'b1;
                     st_q              <= S_DONE;
                  end else if (is_ldst && illegal) begin
                     stat_q[STB_ADDRX] <= 1'b1;
                     st_q              <= S_DONE;
                  end else if (is_ldst) begin
                     addr_q <= first;
                     st_q   <= S_XREQ;
                  end else if (is_rt) begin
                     st_q <= S_REG;
                  end else begin
                     st_q <= S_DONE;
                  end
               end
            end
            S_REG: st_q <= S_DONE;
            S_XREQ: st_q <= S_XCHK;
            S_XCHK: begin
               cnt_q <= cnt_q + 3'h1;
               if (chk_end) begin
                  cnt_q <= 3'h0;
                  if (abort_s_q) begin
                     stat_q[STB_ABORT] <= 1'b1;
                     st_q              <= S_DONE;
                  end else begin
                     words_q <= words_q + 8'h01;
                     if (last_s_q) begin
                        st_q <= S_DONE;
                     end else begin
                        addr_q <= nxt;
                        st_q   <= S_XREQ;
                     end
                  end
               end
            end
            S_DONE: begin
               stat_q[STB_DONE] <= 1'b1;
               st_q             <= S_IDLE;
            end
         endcase
      end
   end
   assign cop_instr_o = instr_q;
   assign cop_offer_o = st_q == S_OFFER;
   assign cop_wdata_o = wdata_q;
   assign mem_addr_o  = addr_q;
   assign mem_req_o   = st_q == S_XREQ;
   assign mem_write_o = !l_bit;
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   property p_first_addr;
      st_q == S_XREQ && words_q == 8'h00 |-> mem_addr_o == first;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("first address wrong");
   property p_pc_base;
      st_q == S_XREQ && words_q == 8'h00 && base_pc && mode32_q && !instr_q[B_P]
         |-> mem_addr_o == pc_q + 32'h8;
   endproperty
   a_pc_base: assert property (p_pc_base) else $error("pc base not pc+8");
   property p_pc_no_wb;
      busy && base_pc |=> $stable(base_q);
   endproperty
   a_pc_no_wb: assert property (p_pc_no_wb) else $error("pc base written back");
   property p_wrap;
      st_q == S_XREQ && !mode32_q |-> mem_addr_o[31:26] == 6'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address outside 26 bits");
   property p_abort_wb;
      chk_end && abort_s_q && w_bit && !base_pc
         |=> base_q == $past(mod_addr) && $stable(flags_q) && stat_q[STB_ABORT];
   endproperty
   a_abort_wb: assert property (p_abort_wb) else $error("abort write-back wrong");
   property p_flags;
      flags_ld |=> flags_q[31:28] == $past(mrc_val[31:28])
         && flags_q[27:0] == $past(flags_q[27:0]) && $stable(pc_q);
   endproperty
   a_flags: assert property (p_flags) else $error("move to pc flags wrong");
   property p_pc12;
      st_q == S_OFFER && cnt_q == 3'h0 && is_rt && !l_bit && rd_pc && mode32_q
         |-> cop_wdata_o == pc_q + 32'hC;
   endproperty
   a_pc12: assert property (p_pc12) else $error("pc+12 not sent");
   property p_undef;
      st_q == S_OFFER && cnt_q == 3'h3 && absent_s_q |=> stat_q[STB_UNDEF] ##1 !busy;
   endproperty
   a_undef: assert property (p_undef) else $error("undefined trap missing");
   property p_skip;
      go && !cond_pass |=> st_q == S_DONE ##1 !busy && !stat_q[STB_UNDEF] && words_q == 8'h00;
   endproperty
   a_skip: assert property (p_skip) else $error("failed condition had effect");
   property p_no_offer_int;
      cop_offer_o |-> !internal;
   endproperty
   a_no_offer_int: assert property (p_no_offer_int) else $error("internal op offered");
   c_ldst: cover property (chk_end && last_s_q && is_ldst);
   c_flags: cover property (flags_ld);
   c_undef: cover property (st_q == S_OFFER && is_undef && absent_s_q);
   c_abort: cover property (chk_end && abort_s_q);
endmodule
`default_nettype wire

// file: core/cph_pkg.sv
`default_nettype none
package cph_pkg;
   // ---------------------------------------------
   // Register map (byte addresses, low byte)
   // ---------------------------------------------
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_INSTR   = 8'h04;
   localparam logic [7:0]  REG_BASE    = 8'h08;
   localparam logic [7:0]  REG_PC      = 8'h0C;
   localparam logic [7:0]  REG_FLAGS   = 8'h10;
   localparam logic [7:0]  REG_XFER    = 8'h14;
   localparam logic [7:0]  REG_STATUS  = 8'h18;
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;
   localparam logic [2:0]  SIZE_WORD   = 3'h2;
   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int CTRL_GO     = 0;
   localparam int CTRL_MODE32 = 1;
   localparam int STB_BUSY    = 0;
   localparam int STB_DONE    = 1;
   localparam int STB_SKIP    = 2;
   localparam int STB_UNDEF   = 3;
   localparam int STB_ADDRX   = 4;
   localparam int STB_ABORT   = 5;
   localparam int STB_NOTCOP  = 6;
   localparam int STB_WORDS   = 8;
   localparam int B_COND      = 28;
   localparam int B_P         = 24;
   localparam int B_U         = 23;
   localparam int B_W         = 21;
   localparam int B_L         = 20;
   localparam int B_BASE      = 16;
   localparam int B_RD        = 12;
   localparam int B_CPN       = 8;
   localparam int B_BIT4      = 4;
   localparam int OFS_SHIFT   = 2;
   // ---------------------------------------------
   // Encodings and constants
   // ---------------------------------------------
   localparam logic [2:0]  CLS_LDST    = 3'h6;
   localparam logic [2:0]  CLS_UNDEF   = 3'h3;
   localparam logic [3:0]  CLS_REGOP   = 4'hE;
   localparam logic [3:0]  PC_REG      = 4'hF;
   localparam logic [3:0]  COP_ONCHIP  = 4'hF;
   localparam logic [31:0] PC_BASE_OFS = 32'h0000_0008;
   localparam logic [31:0] PC_XFER_OFS = 32'h0000_000C;
   localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
   localparam logic [31:0] ADDR26_MASK = 32'h03FF_FFFF;
   localparam logic [31:0] PC26_MASK   = 32'h03FF_FFFC;
   localparam logic [2:0]  CLAIM_WAIT  = 3'h4;
   localparam logic [2:0]  ABORT_WAIT  = 3'h3;
   typedef enum logic [2:0] {
      S_IDLE, S_OFFER, S_REG, S_XREQ, S_XCHK, S_DONE
   } cph_state_e;
endpackage
`default_nettype wire

// file: core/cph_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module cph_cond_eval (
   input  wire logic [3:0] cond_i,
   input  wire logic [3:0] nzcv_i,
   output logic            pass_o
);
   logic n, z, c, v;
   assign {n, z, c, v} = nzcv_i;
   always_comb begin
      unique case (cond_i)
         4'h0: pass_o = z;
         4'h1: pass_o = !z;
         4'h2: pass_o = c;
         4'h3: pass_o = !c;
         4'h4: pass_o = n;
         4'h5: pass_o = !n;
         4'h6: pass_o = v;
         4'h7: pass_o = !v;
         4'h8: pass_o = c && !z;
         4'h9: pass_o = !c || z;
         4'hA: pass_o = n == v;
         4'hB: pass_o = n != v;
         4'hC: pass_o = !z && (n == v);
         4'hD: pass_o = z || (n != v);
         4'hE: pass_o = 1'b1;
         4'hF: pass_o = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// file: verification/cph_cop_model.sv
`timescale 1ns/1ps
`default_nettype none
module cph_cop_model
   import cph_pkg::*;
#(
   parameter logic [3:0] COP_NUM  = 4'h3,
   parameter int         LONG_LEN = 3
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic [31:0] cop_instr_i,
   input  wire logic        cop_offer_i,
   input  wire logic        mem_req_i,
   input  wire logic [31:0] rd_val_i,
   input  wire logic [7:0]  abort_at_i,
   output logic             coprocessor_absent_o,
   output logic [31:0]      cop_rdata_o,
   output logic             cop_last_o,
   output logic             mem_abort_o
);
   // ---------------------------------------------
   // Claim, data and word count
   // ---------------------------------------------
   logic       mine;
   logic       claim;
   logic [7:0] idx_q;
   logic [7:0] len;
   logic [7:0] pos;

   assign mine = (cop_instr_i[11:8] == COP_NUM) &&
                 ((cop_instr_i[27:25] == CLS_LDST) || (cop_instr_i[27:24] == CLS_REGOP));
   assign claim                = cop_offer_i & mine;
   assign coprocessor_absent_o = ~claim;
   // Released data line shows inverse, not a stale value
   assign cop_rdata_o = claim ? rd_val_i : ~rd_val_i;
   assign len         = cop_instr_i[22] ? 8'(LONG_LEN) : 8'h01;
   // Word index held from request through its check cycles
   assign pos         = mem_req_i ? idx_q + 8'h01 : idx_q;
   assign cop_last_o  = (pos == len);
   assign mem_abort_o = (pos == abort_at_i);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || cop_offer_i) begin
         idx_q <= 8'h00;
      end else if (mem_req_i) begin
         idx_q <= idx_q + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cph_pkg::*;
;
   localparam logic [3:0] COP = 4'h3;
   logic        sys_clk   = 1'b0;
   logic        reset_i   = 1'b1;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [31:0] haddr     = 32'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [31:0] rd_val    = 32'h0;
   logic [7:0]  abort_at  = 8'hFF;
   logic [31:0] hrdata, cop_instr, cop_wdata, cop_rdata, mem_addr, off_instr, off_wdata;
   logic        hreadyout, hresp, cop_offer, absent, cop_last, mem_req, mem_write, mem_abort;
   logic        req_wr;
   logic [31:0] addr_q[$];
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc       = 0;
   int          n_offer   = 0;

   always #12.5 sys_clk = ~sys_clk;

   cph_cop_port DUT (
      .sys_clk_i(sys_clk), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(SIZE_WORD), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .cop_instr_o(cop_instr), .cop_offer_o(cop_offer), .cop_wdata_o(cop_wdata),
      .coprocessor_absent_i(absent), .cop_last_i(cop_last), .cop_rdata_i(cop_rdata),
      .mem_addr_o(mem_addr), .mem_req_o(mem_req), .mem_write_o(mem_write),
      .mem_abort_i(mem_abort));

   cph_cop_model #(.COP_NUM(COP), .LONG_LEN(3)) u_cop (
      .sys_clk_i(sys_clk), .reset_i(reset_i), .cop_instr_i(cop_instr),
      .cop_offer_i(cop_offer), .mem_req_i(mem_req), .rd_val_i(rd_val),
      .abort_at_i(abort_at), .coprocessor_absent_o(absent), .cop_rdata_o(cop_rdata),
      .cop_last_o(cop_last), .mem_abort_o(mem_abort));

   // ---------------------------------------------
   // Monitor, timeout and shared tasks
   // ---------------------------------------------
   always @(posedge sys_clk) begin
      cyc++;
      if (mem_req === 1'b1) begin
         addr_q.push_back(mem_addr);
         req_wr = mem_write;
      end
      if (cop_offer === 1'b1) begin
         n_offer++;
         off_instr = cop_instr;
         off_wdata = cop_wdata;
      end
      if (cyc > 20000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(what, exp, x);
   endtask

   task automatic setup(input logic [31:0] b, p, f, x);
      wr(REG_BASE, b);
      wr(REG_PC, p);
      wr(REG_FLAGS, f);
      wr(REG_XFER, x);
   endtask

   function automatic logic [31:0] ldst(logic [3:0] bn, logic p, u, n, w, l, logic [7:0] o);
      return {4'hE, CLS_LDST, p, u, n, w, l, bn, 4'h2, COP, o};
   endfunction

   function automatic logic [31:0] regop(logic l, logic [3:0] rd, logic [3:0] cn);
      return {4'hE, CLS_REGOP, 3'h5, l, 4'h6, rd, cn, 3'h2, 1'b1, 4'h7};
   endfunction

   // Flags: {not coprocessor, abort, address exception, undefined, skipped}
   task automatic go(input logic [31:0] ins, input logic m, input logic [4:0] ef,
                     input logic [7:0] ew);
      logic [31:0] st;
      int          i;
      wr(REG_INSTR, ins);
      addr_q.delete();
      wr(REG_CTRL, {30'h0, m, 1'b1});
      i = 0;
      do begin
         bus(1'b0, REG_STATUS, 32'h0, st);
         i++;
      end while (st[STB_BUSY] !== 1'b0 && i < 100);
      chk("busy", 32'h0, {31'h0, st[STB_BUSY]});
      chk("status", {27'h0, ef}, {27'h0, st[6:2]});
      if (ew !== 8'hFF) begin
         chk("words", {24'h0, ew}, {24'h0, st[15:8]});
      end
   endtask

   task automatic chk_addrs(input logic [31:0] first, input int n);
      chk("request count", 32'(n), 32'(addr_q.size()));
      for (int i = 0; i < n && i < addr_q.size(); i++) begin
         chk("address", {6'h0, first[25:0] + 26'(4 * i)}, addr_q[i]);
      end
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_ldst();
      setup(32'h0000_1001, 32'h0000_0100, 32'h0, 32'h0);
      go(ldst(4'h1, 1, 1, 1, 1, 1, 8'h02), 1'b0, 5'h00, 8'h03);
      chk_addrs(32'h0000_1009, 3);
      chk("load dir", 32'h0, {31'h0, req_wr});
      rdc("base pre", REG_BASE, 32'h0000_1009);
      go(ldst(4'h1, 0, 0, 0, 1, 0, 8'h04), 1'b0, 5'h00, 8'h01);
      chk_addrs(32'h0000_1009, 1);
      chk("store dir", 32'h1, {31'h0, req_wr});
      rdc("base post", REG_BASE, 32'h0000_0FF9);
      go(ldst(4'h1, 1, 1, 0, 0, 0, 8'h01), 1'b0, 5'h00, 8'h01);
      chk_addrs(32'h0000_0FFD, 1);
      rdc("base kept", REG_BASE, 32'h0000_0FF9);
      $display("test ldst done");
   endtask

   task automatic t_pc_addr();
      setup(32'h0000_0055, 32'h0000_0100, 32'hF000_0003, 32'h0);
      go(ldst(4'hF, 1, 1, 0, 1, 1, 8'h01), 1'b0, 5'h00, 8'h01);
      chk_addrs(32'h0000_010C, 1);
      rdc("base no wb", REG_BASE, 32'h0000_0055);
      go(ldst(4'hF, 0, 1, 0, 1, 1, 8'h01), 1'b1, 5'h00, 8'h01);
      chk_addrs(32'h0000_0108, 1);
      rdc("base no wb 32", REG_BASE, 32'h0000_0055);
      wr(REG_BASE, 32'h0400_0000);
      go(ldst(4'h1, 1, 1, 0, 1, 1, 8'h00), 1'b0, 5'h04, 8'h00);
      chk_addrs(32'h0, 0);
      wr(REG_BASE, 32'h03FF_FFFC);
      go(ldst(4'h1, 1, 1, 1, 0, 1, 8'h00), 1'b0, 5'h00, 8'h03);
      chk_addrs(32'h03FF_FFFC, 3);
      $display("test pc base and address done");
   endtask

   task automatic t_abort();
      setup(32'h0000_3000, 32'h0000_0100, 32'hA000_0000, 32'h0);
      abort_at <= 8'h02;
      go(ldst(4'h1, 1, 1, 1, 1, 1, 8'h01), 1'b0, 5'h08, 8'hFF);
      chk_addrs(32'h0000_3004, 2);
      rdc("base abort", REG_BASE, 32'h0000_3004);
      rdc("flags abort", REG_FLAGS, 32'hA000_0000);
      rdc("pc abort", REG_PC, 32'h0000_0100);
      abort_at <= 8'hFF;
      go(ldst(4'h1, 1, 1, 1, 1, 1, 8'h01), 1'b0, 5'h00, 8'h03);
      chk_addrs(32'h0000_3008, 3);
      $display("test abort done");
   endtask

   task automatic t_regs();
      setup(32'h0, 32'h0000_0200, 32'h0C00_0002, 32'h0);
      rd_val <= 32'h5A5A_0F0F;
      go(regop(1, 4'h3, COP), 1'b0, 5'h00, 8'h00);
      chk("offered", regop(1, 4'h3, COP), off_instr);
      rdc("xfer in", REG_XFER, 32'h5A5A_0F0F);
      rd_val <= 32'h9FFF_FFFF;
      go(regop(1, 4'hF, COP), 1'b0, 5'h00, 8'h00);
      rdc("flags 26", REG_FLAGS, 32'h9C00_0002);
      rdc("pc kept", REG_PC, 32'h0000_0200);
      rd_val <= 32'h6000_0000;
      go(regop(1, 4'hF, COP), 1'b1, 5'h00, 8'h00);
      rdc("flags 32", REG_FLAGS, 32'h6C00_0002);
      wr(REG_XFER, 32'h1357_9BDF);
      go(regop(0, 4'h5, COP), 1'b0, 5'h00, 8'h00);
      chk("to cop", 32'h1357_9BDF, off_wdata);
      go(regop(0, 4'hF, COP), 1'b0, 5'h00, 8'h00);
      chk("pc flags", 32'h6C00_0202, off_wdata);
      go(regop(0, 4'hF, COP), 1'b1, 5'h00, 8'h00);
      chk("pc plus", 32'h0000_020C, off_wdata);
      $display("test register transfer done");
   endtask

   task automatic t_undef();
      int n;
      wr(REG_XFER, 32'h0000_00AA);
      wr(REG_FLAGS, 32'h0);
      go(regop(1, 4'h3, 4'h5), 1'b0, 5'h02, 8'h00);
      rdc("xfer kept", REG_XFER, 32'h0000_00AA);
      n = n_offer;
      go(regop(0, 4'h3, COP_ONCHIP), 1'b0, 5'h00, 8'h00);
      wr(REG_XFER, 32'h0);
      go(regop(1, 4'h3, COP_ONCHIP), 1'b0, 5'h00, 8'h00);
      rdc("internal read", REG_XFER, 32'h0000_00AA);
      chk("internal", 32'(n), 32'(n_offer));
      go(32'hE600_0010, 1'b0, 5'h02, 8'h00);
      chk("offer undef", 32'h1, 32'(n_offer > n));
      n = n_offer;
      go(32'h0600_0010, 1'b0, 5'h01, 8'h00);
      go(ldst(4'h1, 1, 1, 0, 0, 1, 8'h00) & 32'h0FFF_FFFF, 1'b0, 5'h01, 8'h00);
      chk("cond fail", 32'(n), 32'(n_offer));
      go(32'hE000_00B1, 1'b0, 5'h10, 8'h00);
      $display("test undefined done");
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      reset_i <= 1'b0;
      @(posedge sys_clk);
      t_ldst();
      t_pc_addr();
      t_abort();
      t_regs();
      t_undef();
      end_sim();
   end
endmodule
`default_nettype wire
